// ===== core/ebi_bus_monitor.sv
// bus monitor: counts termination response time and flags a timeout
`timescale 1ns/1ps
module ebi_bus_monitor
   import ebi_exc_pkg::*;
(
   input  wire logic i_clk,
   input  wire logic i_rstn,
   input  wire logic i_ce,
   ebi_term_if.mon   term
);
   logic [6:0] cnt_r;
   logic [6:0] limit;

   always_comb begin
      case (term.sel)
         2'h0:    limit = MON_PERIOD_0;
         2'h1:    limit = MON_PERIOD_1;
         2'h2:    limit = MON_PERIOD_2;
         default: limit = MON_PERIOD_3;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         cnt_r <= MON_CNT_RESET;
      end else if (i_ce) begin
         if (term.start || !term.active || !term.watch) begin
            cnt_r <= MON_CNT_RESET;
         end else if (cnt_r != limit) begin
            cnt_r <= cnt_r + 7'h01;
         end
      end
   end

   assign term.timeout = term.watch && term.active && !term.start && (cnt_r == limit);
endmodule

// ===== core/ebi_exc_emul_mon.sv
// top: bus termination, abort, emulation region code, show cycles and bus monitor
//
// Summary of operation
// - a cycle ends normally only on external, chip-select or internal transfer acknowledge.
// - transfer error, external or internal, ends the cycle and beats acknowledge.
// - the bus monitor raises the internal transfer error when acknowledge is late.
// - aborted external cycles still drive address, direction, codes, select, enable, strobe.
// - emulation or master mode drives the two-bit region code per access type.
// - ports window gives 10, other registers 11, high space gives 00.
// - region code is only valid during bus cycles and reset.
// - emulation mode sends port registers outside, low address bits pick register.
// - show cycles keep enables negated, data out one clock after internal end.
// - address, codes, size and direction always show internal bus activity.
// - with show cycles off the data bus floats during internal cycles.
// - show cycles always on in emulation, in master mode only by enable bit.
// - show strobe enabled from reset in emulation, else by port E assignment.
// - one show strobe pulse per external or show cycle, low then high.
// - monitor timeout chosen as 8, 16, 32 or 64 clocks.
// - monitor counter clears and restarts at the start of every access.
// - an unterminated cycle past the period ends with an internal bus error.
// - one bit picks internal-only or all monitoring; debug can disable it.
// - a word to a 16-bit port is two external cycles, each monitored.
// - this block raises no interrupt request.
// - wait states in whole clocks until external or chip-select acknowledge.
`timescale 1ns/1ps
module ebi_exc_emul_mon
   import ebi_exc_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_rstn,
   input  wire logic        i_ce,
   // internal bus master side
   input  wire logic        i_req,
   input  wire logic [31:0] i_addr,
   input  wire logic        i_read,
   input  wire logic [2:0]  i_tcode,
   input  wire logic [1:0]  i_tsize,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_abort,
   input  wire logic        i_port16,
   input  wire logic        i_int_ack,
   input  wire logic        i_int_err,
   input  wire logic        i_cs_ack,
   input  wire logic [31:0] i_int_rdata,
   output logic             o_done,
   output logic             o_error,
   output logic [31:0]      o_rdata,
   // configuration bits
   input  wire logic        i_emul_mode,
   input  wire logic        i_master_mode,
   input  wire logic        i_show_cycle_enable,
   input  wire logic        i_porte_pin_assign_bits,
   input  wire logic [1:0]  i_monitor_timeout_sel,
   input  wire logic        i_monitor_external_enable,
   input  wire logic        i_debug_mode,
   input  wire logic        i_debug_monitor_disable,
   input  wire logic [3:0]  i_byte_lanes,
   input  wire logic        i_chip_sel_used,
   // external pins
   input  wire logic        i_transfer_ack_n,
   input  wire logic        i_transfer_error_ack_n,
   input  wire logic [31:0] i_data,
   output logic [31:0]      o_data,
   output logic             o_data_oe_n,
   output logic [31:0]      o_addr,
   output logic             o_rw,
   output logic [2:0]       o_transfer_code,
   output logic [1:0]       o_transfer_size,
   output logic             o_chip_sel_n,
   output logic             o_oe_n,
   output logic [3:0]       o_byte_enable_n,
   output logic [1:0]       o_emul_region_code,
   output logic             o_show_strobe_n,
   output logic             o_show_strobe_oe_n
);
   bus_state_type state_r;
   logic          ta_s1_r, ta_s2_r, tea_s1_r, tea_s2_r;
   logic [31:0]   din_s1_r, din_s2_r;
   logic [31:0]   addr_r;
   logic          read_r;
   logic          ext_r;
   logic          half_r;
   logic          second_r;
   logic [31:0]   wdata_r;
   logic [1:0]    region;
   logic          ext_access;
   logic          show_on;
   logic          strobe_en_r;
   logic          ack_any;
   logic          err_any;
   logic          term_now;

   ebi_term_if term ();

   ebi_region_decode u_region (
      .i_addr (i_addr),
      .o_code (region)
   );

   ebi_bus_monitor u_mon (
      .i_clk  (i_clk),
      .i_rstn (i_rstn),
      .i_ce   (i_ce),
      .term   (term)
   );

   // -----------------------------------------
   // pin synchronisers
   // -----------------------------------------
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         ta_s1_r  <= 1'b1;
         ta_s2_r  <= 1'b1;
         tea_s1_r <= 1'b1;
         tea_s2_r <= 1'b1;
         din_s1_r <= DATA_RESET;
         din_s2_r <= DATA_RESET;
      end else if (i_ce) begin
         // flush once a cycle ends: a stale acknowledge would end the next half early
         if (term_now) begin
            ta_s1_r  <= 1'b1;
            ta_s2_r  <= 1'b1;
            tea_s1_r <= 1'b1;
            tea_s2_r <= 1'b1;
         end else begin
            ta_s1_r  <= i_transfer_ack_n;
            ta_s2_r  <= ta_s1_r;
            tea_s1_r <= i_transfer_error_ack_n;
            tea_s2_r <= tea_s1_r;
         end
         din_s1_r <= i_data;
         din_s2_r <= din_s1_r;
      end
   end

   // -----------------------------------------
   // access classification
   // -----------------------------------------
   // ports go outside in emulation
   assign ext_access = (region == REGION_EXTERNAL) ||
                       (i_emul_mode && region == REGION_PORTS);
   assign show_on = i_emul_mode || (i_master_mode && i_show_cycle_enable);

   // -----------------------------------------
   // termination
   // -----------------------------------------
   // normal end only on acknowledge
   assign ack_any = ext_r ? (!ta_s2_r || i_cs_ack) : i_int_ack;
   // error wins; monitor timeout shares the error path
   assign err_any = (ext_r ? !tea_s2_r : i_int_err) || term.timeout;
   assign term_now = (state_r == ST_WAIT) && (ack_any || err_any);

   assign term.watch  = !(i_debug_mode && i_debug_monitor_disable) &&
                        (!ext_r || i_monitor_external_enable);
   assign term.active = (state_r == ST_WAIT);
   assign term.sel    = i_monitor_timeout_sel;
   // restart on each access; each half of a split word too
   assign term.start  = (state_r == ST_ADDR);

   // -----------------------------------------
   // cycle sequencer
   // -----------------------------------------
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         state_r  <= ST_IDLE;
         addr_r   <= ADDR_RESET;
         read_r   <= 1'b1;
         ext_r    <= 1'b0;
         half_r   <= 1'b0;
         second_r <= 1'b0;
         wdata_r  <= DATA_RESET;
      end else if (i_ce) begin
         case (state_r)
            ST_IDLE: begin
               if (i_req) begin
                  addr_r   <= i_addr;
                  read_r   <= i_read;
                  ext_r    <= ext_access;
                  half_r   <= ext_access && i_port16 && (i_tsize == TSIZ_WORD);
                  second_r <= 1'b0;
                  wdata_r  <= i_wdata;
                  state_r  <= ST_ADDR;
               end
            end
            ST_ADDR: begin
               state_r <= ST_WAIT;
            end
            ST_WAIT: begin
               if (i_abort) begin
                  state_r <= ST_DONE;
               end else if (term_now) begin
                  if (!err_any && half_r && !second_r) begin
                     second_r <= 1'b1;
                     addr_r   <= {addr_r[31:2], 2'h2};
                     state_r  <= ST_ADDR;
                  end else if (!ext_r && show_on && !err_any) begin
                     state_r <= ST_SHOW;
                  end else begin
                     state_r <= ST_DONE;
                  end
               end
            end
            ST_SHOW: begin
               state_r <= ST_DONE;
            end
            ST_DONE: begin
               state_r <= ST_IDLE;
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // -----------------------------------------
   // master answer
   // -----------------------------------------
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         o_done  <= 1'b0;
         o_error <= 1'b0;
         o_rdata <= DATA_RESET;
      end else if (i_ce) begin
         o_done  <= 1'b0;
         o_error <= 1'b0;
         if (term_now && !i_abort && (err_any || !half_r || second_r)) begin
            o_done  <= 1'b1;
            o_error <= err_any;
            if (ext_r) begin
               o_rdata <= half_r ? {o_rdata[31:16], din_s2_r[31:16]} : din_s2_r;
            end else begin
               o_rdata <= i_int_rdata;
            end
         end else if (term_now && half_r && !second_r && ext_r) begin
            o_rdata <= {din_s2_r[31:16], o_rdata[15:0]};
         end
      end
   end

   // -----------------------------------------
   // address and control pins
   // -----------------------------------------
   // pins follow internal activity too; held through an abort
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         o_addr          <= ADDR_RESET;
         o_rw            <= 1'b1;
         o_transfer_code <= TCODE_RESET;
         o_transfer_size <= TSIZ_WORD;
      end else if (i_ce && state_r == ST_IDLE && i_req) begin
         o_addr          <= i_addr;
         o_rw            <= i_read;
         o_transfer_code <= i_tcode;
         o_transfer_size <= i_tsize;
      end else if (i_ce && state_r == ST_WAIT && term_now && half_r && !second_r) begin
         o_addr <= {addr_r[31:2], 2'h2};
      end
   end

   // region code; held at reset value, meaningful only in cycles
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         o_emul_region_code <= REGION_REGS;
      end else if (i_ce && state_r == ST_IDLE && i_req && (i_emul_mode || i_master_mode)) begin
         o_emul_region_code <= region;
      end
   end

   // select, output enable and byte enables for external cycles; negated in show
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         o_chip_sel_n    <= 1'b1;
         o_oe_n          <= 1'b1;
         o_byte_enable_n <= BYTE_EN_IDLE;
      end else if (i_ce) begin
         if (ext_r && (state_r == ST_ADDR || state_r == ST_WAIT)) begin
            o_chip_sel_n    <= !i_chip_sel_used;
            o_oe_n          <= !read_r;
            o_byte_enable_n <= i_abort ? BYTE_EN_IDLE : ~i_byte_lanes;
         end else begin
            o_chip_sel_n    <= 1'b1;
            o_oe_n          <= 1'b1;
            o_byte_enable_n <= BYTE_EN_IDLE;
         end
      end
   end

   // -----------------------------------------
   // data bus
   // -----------------------------------------
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         o_data      <= DATA_RESET;
         o_data_oe_n <= 1'b1;
      end else if (i_ce) begin
         if (ext_r && !read_r && state_r == ST_WAIT) begin
            o_data      <= (half_r && second_r) ? {wdata_r[15:0], 16'h0000} : wdata_r;
            o_data_oe_n <= 1'b0;
         // show data one edge after the internal end
         end else if (!ext_r && term_now && show_on && !err_any) begin
            o_data      <= read_r ? i_int_rdata : wdata_r;
            o_data_oe_n <= 1'b0;
         end else if (state_r == ST_SHOW) begin
            o_data_oe_n <= 1'b0;
         end else begin
            // float when show cycles are off
            o_data_oe_n <= 1'b1;
         end
      end
   end

   // -----------------------------------------
   // show strobe
   // -----------------------------------------
   // enable caught after reset release, emulation or port E assignment
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         strobe_en_r <= 1'b0;
      end else if (i_ce) begin
         strobe_en_r <= i_emul_mode || i_porte_pin_assign_bits;
      end
   end

   // one low pulse per external or show cycle
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         o_show_strobe_n <= 1'b1;
      end else if (i_ce) begin
         // each half of a split word is its own external cycle with its own pulse
         if (state_r == ST_ADDR && (ext_r || show_on)) begin
            o_show_strobe_n <= 1'b0;
         end else if (state_r == ST_SHOW || state_r == ST_DONE ||
                      (term_now && half_r && !second_r)) begin
            o_show_strobe_n <= 1'b1;
         end
      end
   end

   assign o_show_strobe_oe_n = !strobe_en_r;
endmodule

// ===== core/ebi_exc_pkg.sv
// package: constants and types for the bus exception, emulation and monitor block
package ebi_exc_pkg;
   // region code values
   localparam logic [1:0] REGION_EXTERNAL = 2'h0;
   localparam logic [1:0] REGION_INTERNAL = 2'h1;
   localparam logic [1:0] REGION_PORTS    = 2'h2;
   localparam logic [1:0] REGION_REGS     = 2'h3;
   // address windows
   localparam logic [31:0] PORTS_BASE = 32'h00c0_0000;
   localparam logic [31:0] PORTS_LAST = 32'h00c0_ffff;
   localparam logic [31:0] REGS_BASE  = 32'h00c1_0000;
   localparam logic [31:0] REGS_LAST  = 32'h00ff_ffff;
   localparam logic [31:0] EXT_BASE   = 32'h8000_0000;
   // monitor periods in system clocks, selected by a two-bit field
   localparam logic [6:0] MON_PERIOD_0 = 7'h08;
   localparam logic [6:0] MON_PERIOD_1 = 7'h10;
   localparam logic [6:0] MON_PERIOD_2 = 7'h20;
   localparam logic [6:0] MON_PERIOD_3 = 7'h40;
   localparam logic [6:0] MON_CNT_RESET = 7'h00;
   // pin levels after reset
   localparam logic [3:0] BYTE_EN_IDLE = 4'hf;
   localparam logic [1:0] TSIZ_WORD    = 2'h0;
   localparam logic [2:0] TCODE_RESET  = 3'h0;
   localparam logic [31:0] DATA_RESET  = 32'h0000_0000;
   localparam logic [31:0] ADDR_RESET  = 32'h0000_0000;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_ADDR  = 3'b001,
      ST_WAIT  = 3'b010,
      ST_SHOW  = 3'b011,
      ST_DONE  = 3'b100
   } bus_state_type;
endpackage

// ===== core/ebi_region_decode.sv
// region decoder: classifies an address into the emulation region code
`timescale 1ns/1ps
module ebi_region_decode
   import ebi_exc_pkg::*;
(
   input  wire logic [31:0] i_addr,
   output logic      [1:0]  o_code
);
   always_comb begin
      if (i_addr >= EXT_BASE) begin
         o_code = REGION_EXTERNAL;
      end else if (i_addr >= PORTS_BASE && i_addr <= PORTS_LAST) begin
         o_code = REGION_PORTS;
      end else if (i_addr >= REGS_BASE && i_addr <= REGS_LAST) begin
         o_code = REGION_REGS;
      end else begin
         o_code = REGION_INTERNAL;
      end
   end
endmodule

// ===== core/ebi_term_if.sv
// interface: termination handshake between the main block and its monitor
`timescale 1ns/1ps
interface ebi_term_if;
   logic       start;
   logic       active;
   logic       watch;
   logic [1:0] sel;
   logic       timeout;
   modport ctrl (output start, output active, output watch, output sel, input timeout);
   modport mon  (input start, input active, input watch, input sel, output timeout);
endinterface

// ===== verif/ebi_exc_emul_mon_monitor.sv
// checker: pin relations of the bus exception, emulation and monitor block
`timescale 1ns/1ps
module ebi_exc_emul_mon_monitor
   import ebi_exc_pkg::*;
(
   input wire logic        i_clk,
   input wire logic        i_rstn,
   input wire logic        i_req,
   input wire logic        i_emul_mode,
   input wire logic        i_show_cycle_enable,
   input wire logic [1:0]  i_monitor_timeout_sel,
   input wire logic        i_debug_mode,
   input wire logic        i_debug_monitor_disable,
   input wire logic        o_done,
   input wire logic        o_error,
   input wire logic        o_data_oe_n,
   input wire logic [31:0] o_addr,
   input wire logic        o_rw,
   input wire logic        o_oe_n,
   input wire logic [3:0]  o_byte_enable_n,
   input wire logic [1:0]  o_emul_region_code
);
   // ------------------------------
   // wait counter and properties
   // ------------------------------
   logic [7:0] wait_cnt_r;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   // counts from the raise of a request, so the bound carries a few cycles of slack
   always_ff @(posedge i_clk) begin
      if (!i_rstn || !i_req || o_done) begin
         wait_cnt_r <= 8'h00;
      end else if (wait_cnt_r != 8'hff) begin
         wait_cnt_r <= wait_cnt_r + 8'h01;
      end
   end
   property p_err_done; o_error |-> o_done; endproperty
   a_err_done: assert property (p_err_done) else $error("error without done");
   property p_done_once; o_done |=> !o_done ##1 !o_done; endproperty
   a_done_once: assert property (p_done_once) else $error("done repeated");
   property p_reset_state; disable iff (1'b0)
      !i_rstn |=> !o_done && o_data_oe_n && o_emul_region_code == REGION_REGS; endproperty
   a_reset_state: assert property (p_reset_state) else $error("bad reset state");
   property p_region_ports; o_done && i_emul_mode && o_addr >= PORTS_BASE
      && o_addr <= PORTS_LAST |-> o_emul_region_code == REGION_PORTS; endproperty
   a_region_ports: assert property (p_region_ports) else $error("ports code");
   property p_region_ext;
      o_done && o_addr >= EXT_BASE |-> o_emul_region_code == REGION_EXTERNAL; endproperty
   a_region_ext: assert property (p_region_ext) else $error("external code");
   property p_show_lanes;
      !o_data_oe_n && o_rw |-> o_oe_n && o_byte_enable_n == BYTE_EN_IDLE; endproperty
   a_show_lanes: assert property (p_show_lanes) else $error("show enables");
   property p_show_off; !i_emul_mode && !i_show_cycle_enable && o_rw
      && o_addr < EXT_BASE |-> o_data_oe_n; endproperty
   a_show_off: assert property (p_show_off) else $error("data driven");
   property p_mon_bound; i_req && o_addr < EXT_BASE && !(i_debug_mode && i_debug_monitor_disable)
      |-> wait_cnt_r <= (8'h08 << i_monitor_timeout_sel) + 8'h06; endproperty
   a_mon_bound: assert property (p_mon_bound) else $error("wait too long");
endmodule

bind ebi_exc_emul_mon ebi_exc_emul_mon_monitor ebi_exc_emul_mon_monitor_i (.i_clk, .i_rstn,
   .i_req, .i_emul_mode, .i_show_cycle_enable, .i_monitor_timeout_sel, .i_debug_mode,
   .i_debug_monitor_disable, .o_done, .o_error, .o_data_oe_n, .o_addr, .o_rw, .o_oe_n,
   .o_byte_enable_n, .o_emul_region_code);

// ===== verif/ebi_exc_emul_mon_test.sv
// testbench: scenarios for the bus exception, emulation and monitor block
`timescale 1ns/1ps
module ebi_exc_emul_mon_test import ebi_exc_pkg::*; ;
   logic        i_clk = 1'b0, i_rstn = 1'b0, i_req = 1'b0, i_read = 1'b1, i_abort = 1'b0;
   logic        i_port16 = 1'b0, i_emul_mode = 1'b0, i_master_mode = 1'b1, iok = 1'b1;
   logic        i_show_cycle_enable = 1'b0, i_porte_pin_assign_bits = 1'b0, mute = 1'b0;
   logic        i_monitor_external_enable = 1'b0, i_debug_mode = 1'b0, perr = 1'b0;
   logic        i_debug_monitor_disable = 1'b0, ierr = 1'b0, csack = 1'b0;
   logic [1:0]  i_monitor_timeout_sel = 2'h0;
   logic [2:0]  i_tcode = 3'h0;
   logic [3:0]  dly = 4'h1;
   logic [31:0] i_addr = 32'h0000_0000, i_wdata = 32'h0000_0000, i_int_rdata = 32'h0000_0000;
   wire         i_int_ack = i_req & iok;
   wire         i_int_err = i_req & ierr;
   logic        i_transfer_ack_n, i_transfer_error_ack_n, o_done, o_error, o_data_oe_n, o_rw;
   logic        o_chip_sel_n, o_oe_n, o_show_strobe_n, o_show_strobe_oe_n;
   logic [31:0] i_data, o_rdata, o_data, o_addr, rd_r;
   logic [2:0]  o_transfer_code;
   logic [1:0]  o_transfer_size, o_emul_region_code;
   logic [3:0]  o_byte_enable_n;
   int          n_mismatch = 0, n_compared = 0, n_fall = 0, cyc = 0;

   ebi_exc_emul_mon ebi_exc_emul_mon_i (.i_clk, .i_rstn, .i_ce(1'b1), .i_req, .i_addr, .i_read,
      .i_tcode, .i_tsize(TSIZ_WORD), .i_wdata, .i_abort, .i_port16, .i_int_ack, .i_int_err,
      .i_cs_ack(csack), .i_int_rdata, .o_done, .o_error, .o_rdata, .i_emul_mode, .i_master_mode,
      .i_show_cycle_enable, .i_porte_pin_assign_bits, .i_monitor_timeout_sel,
      .i_monitor_external_enable, .i_debug_mode, .i_debug_monitor_disable,
      .i_byte_lanes(4'hf), .i_chip_sel_used(1'b1), .i_transfer_ack_n, .i_transfer_error_ack_n,
      .i_data, .o_data, .o_data_oe_n, .o_addr, .o_rw, .o_transfer_code, .o_transfer_size,
      .o_chip_sel_n, .o_oe_n, .o_byte_enable_n, .o_emul_region_code, .o_show_strobe_n,
      .o_show_strobe_oe_n);
   ext_mem_model ext_mem_model_i (.i_clk, .i_rstn, .i_mute(mute), .i_err(perr), .i_dly(dly),
      .i_addr(o_addr), .i_rw(o_rw), .i_sel_n(o_chip_sel_n), .i_oe_n(o_oe_n),
      .o_ack_n(i_transfer_ack_n), .o_err_n(i_transfer_error_ack_n), .o_data(i_data));

   // ------------------------------
   // clock, watchdog and helpers
   // ------------------------------
   initial forever #50 i_clk = ~i_clk;
   always @(negedge o_show_strobe_n) n_fall++;
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         stop_test();
      end
   end
   task automatic stop_test();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tick();
      @(posedge i_clk);
      #1;
   endtask
   task automatic rst(input logic emul, input logic porte);
      i_rstn = 1'b0;
      i_emul_mode = emul;
      i_master_mode = !emul;
      i_porte_pin_assign_bits = porte;
      repeat (12) tick();
      i_rstn = 1'b1;
      repeat (2) tick();
   endtask
   // a hung access is left in wait after lim cycles, for the caller to abort
   task automatic acc(input logic [31:0] a, input int lim, output logic e, output int n);
      tick();
      i_req = 1'b1;
      i_addr = a;
      i_tcode = a[4:2];
      i_wdata = ~a;
      i_int_rdata = a ^ 32'h5a5a_0000;
      n_fall = 0;
      n = 0;
      tick();
      while (o_done !== 1'b1 && n < lim) begin
         tick();
         n++;
      end
      e = o_error;
      rd_r = o_rdata;
      i_req = 1'b0;
   endtask
   task automatic abort_chk();
      i_abort = 1'b1;
      repeat (4) begin
         tick();
         chk("done_on_abort", o_done, 0);
      end
      i_abort = 1'b0;
   endtask

   // ------------------------------
   // scenarios
   // ------------------------------
   task automatic t_region();
      logic [31:0] a [4] = '{PORTS_BASE + 32'h0000_0014, REGS_BASE + 32'h0000_0100,
                             32'h0000_1000, EXT_BASE + 32'h0000_0040};
      logic [1:0]  c [4] = '{REGION_PORTS, REGION_REGS, REGION_INTERNAL, REGION_EXTERNAL};
      logic        e;
      int          n;
      for (int k = 0; k < 4; k++) begin
         acc(a[k], 60, e, n);
         chk("region", o_emul_region_code, c[k]);
         chk("addr", o_addr, a[k]);
         chk("tcode", o_transfer_code, a[k][4:2]);
         chk("tsize", o_transfer_size, TSIZ_WORD);
         chk("error", e, 0);
         repeat (2) tick();
         chk("strobes", n_fall, 1);
      end
   endtask
   task automatic t_show(input logic s);
      logic e;
      int   n;
      acc(32'h0000_2000, 60, e, n);
      repeat (2) begin
         if (o_data_oe_n === 1'b1) tick();
      end
      chk("show_drive", o_data_oe_n, !s);
      if (s) begin
         chk("show_data", o_data, 32'h5a5a_2000);
         chk("show_oe", o_oe_n, 1);
         chk("show_lanes", o_byte_enable_n, BYTE_EN_IDLE);
      end
      chk("rdata", rd_r, 32'h5a5a_2000);
      repeat (3) tick();
   endtask
   task automatic t_errs();
      logic e;
      int   n;
      perr = 1'b1;
      i_read = 1'b0;
      acc(EXT_BASE + 32'h0000_0080, 60, e, n);
      chk("ext_error", e, 1);
      perr = 1'b0;
      ierr = 1'b1;
      acc(32'h0000_0400, 60, e, n);
      chk("int_error", e, 1);
      ierr = 1'b0;
      i_read = 1'b1;
   endtask
   task automatic t_timeout();
      logic e;
      int   n;
      iok = 1'b0;
      for (int s = 0; s < 4; s++) begin
         i_monitor_timeout_sel = s[1:0];
         acc(32'h0000_3000, 200, e, n);
         chk("timeout_error", e, 1);
         chk("timeout_span", n >= (8 << s) && n <= (8 << s) + 4, 1);
      end
      iok = 1'b1;
   endtask
   task automatic t_port16();
      logic e;
      int   n;
      i_port16 = 1'b1;
      i_monitor_external_enable = 1'b1;
      i_monitor_timeout_sel = 2'h0;
      dly = 4'h2;
      acc(EXT_BASE + 32'h0000_0100, 80, e, n);
      chk("split_error", e, 0);
      chk("split_rdata", rd_r, 32'h0100_0102);
      chk("split_addr", o_addr, EXT_BASE + 32'h0000_0102);
      chk("split_strobes", n_fall, 2);
      i_port16 = 1'b0;
      dly = 4'h1;
   endtask
   task automatic t_ext_mon();
      logic e;
      int   n;
      mute = 1'b1;
      i_monitor_external_enable = 1'b0;
      acc(EXT_BASE + 32'h0000_0200, 100, e, n);
      chk("unwatched_wait", n, 100);
      chk("abort_addr", o_addr, EXT_BASE + 32'h0000_0200);
      chk("abort_rw", o_rw, 1);
      chk("abort_cs", o_chip_sel_n, 0);
      chk("abort_oe", o_oe_n, 0);
      abort_chk();
      csack = 1'b1;
      acc(EXT_BASE + 32'h0000_0300, 100, e, n);
      chk("cs_ack_end", e, 0);
      chk("cs_ack_wait", n, 2);
      csack = 1'b0;
      i_monitor_external_enable = 1'b1;
      acc(EXT_BASE + 32'h0000_0200, 100, e, n);
      chk("ext_timeout", e, 1);
      mute = 1'b0;
      iok = 1'b0;
      i_debug_mode = 1'b1;
      i_debug_monitor_disable = 1'b1;
      acc(32'h0000_3000, 100, e, n);
      chk("debug_wait", n, 100);
      abort_chk();
      iok = 1'b1;
      i_debug_mode = 1'b0;
   endtask

   initial begin
      rst(1'b1, 1'b0);
      chk("strobe_pin_emul", o_show_strobe_oe_n, 0);
      t_region();
      t_show(1'b1);
      t_errs();
      rst(1'b0, 1'b0);
      chk("strobe_pin_master", o_show_strobe_oe_n, 1);
      t_show(1'b0);
      i_show_cycle_enable = 1'b1;
      t_show(1'b1);
      i_show_cycle_enable = 1'b0;
      t_timeout();
      t_port16();
      t_ext_mon();
      rst(1'b0, 1'b1);
      chk("strobe_pin_assigned", o_show_strobe_oe_n, 0);
      stop_test();
   end
endmodule

// ===== verif/ext_mem_model.sv
// partner: external memory answering on the bus pins
`timescale 1ns/1ps
module ext_mem_model (
   input  wire logic        i_clk,
   input  wire logic        i_rstn,
   input  wire logic        i_mute,
   input  wire logic        i_err,
   input  wire logic [3:0]  i_dly,
   input  wire logic [31:0] i_addr,
   input  wire logic        i_rw,
   input  wire logic        i_sel_n,
   input  wire logic        i_oe_n,
   output logic             o_ack_n = 1'b1,
   output logic             o_err_n = 1'b1,
   output logic [31:0]      o_data = 32'h0000_0000
);
   // ------------------------------
   // answer logic
   // ------------------------------
   logic [3:0]  cnt_r = 4'h0;
   logic [31:0] addr_r = 32'h0000_0000;
   always @(posedge i_clk) begin
      #1;
      // whole-clock waits, a write one more
      if (i_sel_n || i_addr !== addr_r) cnt_r = 4'h0;
      else if (cnt_r != 4'hf) cnt_r = cnt_r + 4'h1;
      addr_r = i_addr;
      o_ack_n = i_sel_n || i_mute || cnt_r < i_dly + {3'h0, !i_rw};
      o_err_n = o_ack_n || !i_err;
      // flash line low in reset; a released bus shows the inverse
      if (!i_rstn) o_data = 32'h0000_0000;
      else if (!i_oe_n) o_data = {i_addr[15:0], ~i_addr[15:0]};
      else o_data = ~o_data;
   end
endmodule
